// ===== phy_hw_config.sv
// hardware configuration pins, per-port management bits and reset extension
// Summary of operation
// [RQ1] with autoneg on, cfg0 rising restarts autoneg on all ports, sets 0.9
// [RQ2] with autoneg off, cfg0 high picks 100 Mbps (0.13=1), low 10 Mbps
// [RQ3] with autoneg on, cfg1, cfg2 and full-duplex pin set advertised abilities
// [RQ4] with autoneg off, cfg1 high disables 10M link test, 19.8 follows
// [RQ5] with autoneg off, cfg2 low twisted pair, high fiber, 19.2 follows
// [RQ6] a port in fiber mode has its scrambler disabled automatically
// [RQ7] the board must pick 100 Mbps whenever it picks fiber; strap_board forces cfg0 high only for fiber chosen through cfg2
// [RQ8] the board should pick interface through each port's own select pin
// [RQ9] all-port full-duplex pin high enables full duplex on every port
// [RQ10] fiber full-duplex pin enables full duplex on fiber ports only
// [RQ11] in twisted pair, scrambler-bypass pin drives 19.3 and the bypass
// [RQ12] in fiber mode scrambler is always bypassed, bypass pin ignored
// [RQ13] autoneg enable pin high enables autoneg on all four ports
// [RQ14] management address is three strap bits above the two-bit port number
// [RQ15] reset input and control bit 0.15 both reset the device
// [RQ16] internal reset lasts a further nominal 205 us after release
// [RQ17] power-down pin high or bit 0.11 forces power-down
// [RQ18] the board supplies a continuous reference clock
// [RQ19] management disable high: registers read-only, pins drive bits continuously
// [RQ20] management disable low: pins load defaults, then software owns bits
// [RQ21] pins pass two flip-flops; cfg0 edge found on synchronised level
//
// Local design decisions: the address-and-strobe port and the address map.
module phy_hw_config #(
	parameter int RESET_EXT_CYC = phy_cfg_pkg::RESET_EXT_CYC
) (
	input  wire logic                              clk,
	input  wire logic                              resetn,
	input  wire logic                              cfg0_pin,
	input  wire logic                              cfg1_pin,
	input  wire logic                              cfg2_pin,
	input  wire logic                              all_port_full_duplex_pin,
	input  wire logic                              fiber_full_duplex_pin,
	input  wire logic                              scrambler_bypass_pin,
	input  wire logic                              autoneg_enable_pin,
	input  wire logic                              phy_addr_strap_bit4,
	input  wire logic                              phy_addr_strap_bit3,
	input  wire logic                              phy_addr_strap_bit2,
	input  wire logic                              power_down_pin,
	input  wire logic                              management_disable_pin,
	input  wire logic [phy_cfg_pkg::NUM_PORTS-1:0] port_fx_select_pin,
	input  wire logic [phy_cfg_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic [phy_cfg_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                              reg_wr,
	input  wire logic                              reg_rd,
	output logic      [phy_cfg_pkg::DATA_W-1:0]    reg_rdata,
	output logic                                   device_reset,
	output logic                                   mgmt_read_only,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] speed_100,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] autoneg_en,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] autoneg_restart,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] full_duplex,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] link_test_dis,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] fx_mode,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] scrambler_bypassed,
	output logic      [phy_cfg_pkg::NUM_PORTS-1:0] power_down,
	output logic      [3:0]                        adv_ability,
	output logic      [phy_cfg_pkg::PHY_ADDR_W-1:0] phy_addr_p0,
	output logic      [phy_cfg_pkg::PHY_ADDR_W-1:0] phy_addr_p1,
	output logic      [phy_cfg_pkg::PHY_ADDR_W-1:0] phy_addr_p2,
	output logic      [phy_cfg_pkg::PHY_ADDR_W-1:0] phy_addr_p3
);
	localparam int NP = phy_cfg_pkg::NUM_PORTS;
	localparam int DW = phy_cfg_pkg::DATA_W;

	// control register value that the pins ask for
	function automatic logic [15:0] pin_ctrl(input logic an, input logic spd,
		input logic fd);
		logic [15:0] v;
		v = phy_cfg_pkg::REG_RST_VAL;
		v[phy_cfg_pkg::CTRL_AN_EN]  = an;
		v[phy_cfg_pkg::CTRL_SPEED]  = an | spd;
		v[phy_cfg_pkg::CTRL_DUPLEX] = fd;
		return v;
	endfunction : pin_ctrl

	// configuration register value that the pins ask for
	function automatic logic [15:0] pin_cfg(input logic an, input logic lt,
		input logic fx, input logic byp);
		logic [15:0] v;
		v = phy_cfg_pkg::REG_RST_VAL;
		v[phy_cfg_pkg::CFG_LINK_TEST_DIS] = ~an & lt;
		v[phy_cfg_pkg::CFG_FX]            = fx;
		v[phy_cfg_pkg::CFG_SCR_BYPASS]    = fx | byp;
		return v;
	endfunction : pin_cfg

	// merge a bus write under a field mask
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] mask);
		return (old & ~mask) | (wd & mask);
	endfunction : merge

	// synchronised pins
	logic [11:0] pin_raw;
	logic [11:0] pin_s;
	logic        cfg0_s;
	logic        cfg1_s;
	logic        cfg2_s;
	logic        fde_s;
	logic        fiber_full_duplex_pin_s;
	logic        byp_s;
	logic        an_s;
	logic        pd_s;
	logic        management_disable_pin_s;
	logic [2:0]  strap_s;
	logic [NP-1:0] port_fx_s;

	assign pin_raw = {cfg0_pin, cfg1_pin, cfg2_pin, all_port_full_duplex_pin,
		fiber_full_duplex_pin, scrambler_bypass_pin, autoneg_enable_pin,
		phy_addr_strap_bit4, phy_addr_strap_bit3, phy_addr_strap_bit2,
		power_down_pin, management_disable_pin};

	cfg_sync #(.W(12)) u_pin_sync ( // [RQ21]
		.clk    (clk),
		.resetn (resetn),
		.d      (pin_raw),
		.q      (pin_s)
	);

	cfg_sync #(.W(NP)) u_port_sync ( // [RQ21]
		.clk    (clk),
		.resetn (resetn),
		.d      (port_fx_select_pin),
		.q      (port_fx_s)
	);

	assign cfg0_s   = pin_s[11];
	assign cfg1_s   = pin_s[10];
	assign cfg2_s   = pin_s[9];
	assign fde_s    = pin_s[8];
	assign fiber_full_duplex_pin_s = pin_s[7];
	assign byp_s    = pin_s[6];
	assign an_s     = pin_s[5];
	assign strap_s  = pin_s[4:2];
	assign pd_s     = pin_s[1];
	assign management_disable_pin_s  = pin_s[0];

	// edge of cfg0 taken from the synchronised level only
	logic cfg0_d_ff;
	logic cfg0_rise;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) cfg0_d_ff <= 1'b0;
		else cfg0_d_ff <= cfg0_s;
	end

	assign cfg0_rise = cfg0_s & ~cfg0_d_ff; // [RQ21]

	// internal reset: reset input or any port's reset bit, then extended
	logic [DW-1:0] ctrl_ff [NP];
	logic [DW-1:0] cfg_ff [NP];
	logic [NP-1:0] soft_rst;
	logic          rst_trigger;
	logic          rst_active;

	assign rst_trigger = |soft_rst; // [RQ15]

	reset_stretch #(.CYC(RESET_EXT_CYC)) u_stretch ( // [RQ16]
		.clk     (clk),
		.resetn  (resetn),
		.trigger (rst_trigger),
		.active  (rst_active)
	);

	// ownership of register bits
	phy_cfg_pkg::ctrl_mode_t mode_ff;
	phy_cfg_pkg::ctrl_mode_t nxt_mode;

	always_comb begin
		nxt_mode = mode_ff;
		if (rst_active) begin
			nxt_mode = phy_cfg_pkg::MODE_LOAD;
		end else begin
			unique case (mode_ff)
				phy_cfg_pkg::MODE_LOAD,
				phy_cfg_pkg::MODE_TRACK,
				phy_cfg_pkg::MODE_SOFT: begin
					nxt_mode = management_disable_pin_s ? phy_cfg_pkg::MODE_TRACK : phy_cfg_pkg::MODE_SOFT;
				end
				default: begin
					nxt_mode = phy_cfg_pkg::MODE_LOAD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) mode_ff <= phy_cfg_pkg::MODE_LOAD;
		else mode_ff <= nxt_mode;
	end

	logic in_load;
	logic in_track;
	logic in_soft;
	logic [1:0] wr_port;
	logic [4:0] wr_reg;

	assign in_load  = (mode_ff == phy_cfg_pkg::MODE_LOAD);
	assign in_track = (mode_ff == phy_cfg_pkg::MODE_TRACK);
	assign in_soft  = (mode_ff == phy_cfg_pkg::MODE_SOFT) & ~management_disable_pin_s; // [RQ19]
	assign wr_port  = reg_addr[phy_cfg_pkg::ADDR_W-1:phy_cfg_pkg::PORT_SEL_LSB];
	assign wr_reg   = reg_addr[phy_cfg_pkg::PORT_SEL_LSB-1:0];

	// per-port register bits
	for (genvar p = 0; p < NP; p++) begin : g_port
		logic          an_bit;
		logic          fx_sel;
		logic          fd_sel;
		logic [DW-1:0] ctrl_pin;
		logic [DW-1:0] cfg_pin;
		logic          wr_ctrl;
		logic          wr_cfg;
		logic [DW-1:0] nxt_ctrl;
		logic [DW-1:0] nxt_cfg;

		assign an_bit   = ctrl_ff[p][phy_cfg_pkg::CTRL_AN_EN];
		// global cfg2 selects fiber only with autoneg off; the port pin always can
		assign fx_sel   = port_fx_s[p] | (~an_s & cfg2_s); // [RQ5]
		assign fd_sel   = fde_s | (fx_sel & fiber_full_duplex_pin_s); // [RQ9] [RQ10]
		assign ctrl_pin = pin_ctrl(an_s, cfg0_s, fd_sel); // [RQ2] [RQ13]
		assign cfg_pin  = pin_cfg(an_s, cfg1_s, fx_sel, byp_s); // [RQ4] [RQ11] [RQ12]
		assign wr_ctrl  = reg_wr & in_soft & (wr_port == 2'(p)) &
			(wr_reg == phy_cfg_pkg::REG_CTRL);
		assign wr_cfg   = reg_wr & in_soft & (wr_port == 2'(p)) &
			(wr_reg == phy_cfg_pkg::REG_CFG);
		assign soft_rst[p] = ctrl_ff[p][phy_cfg_pkg::CTRL_RESET];

		always_comb begin
			nxt_ctrl = ctrl_ff[p];
			nxt_cfg  = cfg_ff[p];
			if (in_load || in_track) begin
				// pins load defaults, and keep driving while management is disabled
				nxt_ctrl = ctrl_pin; // [RQ19] [RQ20]
				nxt_cfg  = cfg_pin;
			end else begin
				nxt_ctrl[phy_cfg_pkg::CTRL_AN_RESTART] = 1'b0;
				if (wr_ctrl) nxt_ctrl = merge(nxt_ctrl, reg_wdata, phy_cfg_pkg::CTRL_WR_MASK); // [RQ20]
				if (wr_cfg) nxt_cfg = merge(nxt_cfg, reg_wdata, phy_cfg_pkg::CFG_WR_MASK);
			end
			// restart request wins over its own self-clear and over a write
			if (!in_load && an_bit && cfg0_rise) begin
				nxt_ctrl[phy_cfg_pkg::CTRL_AN_RESTART] = 1'b1; // [RQ1]
			end
		end

		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				ctrl_ff[p] <= phy_cfg_pkg::REG_RST_VAL;
				cfg_ff[p]  <= phy_cfg_pkg::REG_RST_VAL;
			end else begin
				ctrl_ff[p] <= nxt_ctrl;
				cfg_ff[p]  <= nxt_cfg;
			end
		end
	end

	// advertised abilities; cfg1 offers 100M, cfg2 or a missing 100M offers 10M
	logic       adv_100;
	logic       adv_10;
	logic [3:0] nxt_adv;

	assign adv_100 = cfg1_s;
	assign adv_10  = cfg2_s | ~cfg1_s;
	assign nxt_adv = an_s ? {adv_100 & fde_s, adv_100, adv_10 & fde_s, adv_10} : 4'h0; // [RQ3]

	// register read mux, answer stands in the cycle after the strobe
	logic [DW-1:0] rd_val;
	logic [DW-1:0] rd_ctrl;
	logic [DW-1:0] rd_cfg;
	logic [DW-1:0] rd_adv;
	logic [3:0]    adv_ff;

	assign rd_ctrl = ctrl_ff[wr_port];
	assign rd_cfg  = cfg_ff[wr_port] | ({{(DW-1){1'b0}}, cfg_ff[wr_port][phy_cfg_pkg::CFG_FX]}
		<< phy_cfg_pkg::CFG_SCR_BYPASS);
	assign rd_adv  = {{(DW-4){1'b0}}, adv_ff} << phy_cfg_pkg::ADV_10_HD;
	assign rd_val  = (wr_reg == phy_cfg_pkg::REG_CTRL) ? rd_ctrl :
		(wr_reg == phy_cfg_pkg::REG_CFG) ? rd_cfg :
		(wr_reg == phy_cfg_pkg::REG_ADV) ? rd_adv : '0;

	// registered outputs
	logic [DW-1:0]   rdata_ff;
	logic            dev_rst_ff;
	logic            ro_ff;
	logic [NP-1:0]   speed_ff;
	logic [NP-1:0]   an_ff;
	logic [NP-1:0]   restart_ff;
	logic [NP-1:0]   dup_ff;
	logic [NP-1:0]   lt_ff;
	logic [NP-1:0]   fx_ff;
	logic [NP-1:0]   scr_ff;
	logic [NP-1:0]   pd_ff;
	logic [NP*5-1:0] addr_ff;
	logic [NP-1:0]   nxt_speed;
	logic [NP-1:0]   nxt_an;
	logic [NP-1:0]   nxt_restart;
	logic [NP-1:0]   nxt_dup;
	logic [NP-1:0]   nxt_lt;
	logic [NP-1:0]   nxt_fx;
	logic [NP-1:0]   nxt_scr;
	logic [NP-1:0]   nxt_pd;
	logic [NP*5-1:0] nxt_addr;

	for (genvar p = 0; p < NP; p++) begin : g_out
		assign nxt_speed[p]   = ctrl_ff[p][phy_cfg_pkg::CTRL_SPEED];
		assign nxt_an[p]      = ctrl_ff[p][phy_cfg_pkg::CTRL_AN_EN];
		assign nxt_restart[p] = ctrl_ff[p][phy_cfg_pkg::CTRL_AN_RESTART];
		assign nxt_dup[p]     = ctrl_ff[p][phy_cfg_pkg::CTRL_DUPLEX];
		assign nxt_lt[p]      = cfg_ff[p][phy_cfg_pkg::CFG_LINK_TEST_DIS];
		assign nxt_fx[p]      = cfg_ff[p][phy_cfg_pkg::CFG_FX];
		assign nxt_scr[p]     = cfg_ff[p][phy_cfg_pkg::CFG_SCR_BYPASS] |
			cfg_ff[p][phy_cfg_pkg::CFG_FX]; // [RQ6] [RQ12]
		assign nxt_pd[p]      = ctrl_ff[p][phy_cfg_pkg::CTRL_POWER_DOWN_PIN] | pd_s; // [RQ17]
		assign nxt_addr[p*5 +: 5] = {strap_s, 2'(p)}; // [RQ14]
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= '0;
			adv_ff   <= '0;
			dev_rst_ff <= 1'b1;
			ro_ff    <= 1'b0;
			{speed_ff, an_ff, restart_ff, dup_ff} <= '0;
			{lt_ff, fx_ff, scr_ff, pd_ff} <= '0;
			addr_ff  <= '0;
		end else begin
			rdata_ff <= reg_rd ? rd_val : '0;
			adv_ff   <= nxt_adv;
			dev_rst_ff <= rst_active; // [RQ15] [RQ16]
			ro_ff    <= management_disable_pin_s; // [RQ19]
			{speed_ff, an_ff, restart_ff, dup_ff} <= {nxt_speed, nxt_an, nxt_restart, nxt_dup};
			{lt_ff, fx_ff, scr_ff, pd_ff} <= {nxt_lt, nxt_fx, nxt_scr, nxt_pd};
			addr_ff  <= nxt_addr;
		end
	end

	assign reg_rdata          = rdata_ff;
	assign device_reset       = dev_rst_ff;
	assign mgmt_read_only     = ro_ff;
	assign speed_100          = speed_ff;
	assign autoneg_en         = an_ff;
	assign autoneg_restart    = restart_ff;
	assign full_duplex        = dup_ff;
	assign link_test_dis      = lt_ff;
	assign fx_mode            = fx_ff;
	assign scrambler_bypassed = scr_ff;
	assign power_down         = pd_ff;
	assign adv_ability        = adv_ff;
	assign phy_addr_p0        = addr_ff[4:0];
	assign phy_addr_p1        = addr_ff[9:5];
	assign phy_addr_p2        = addr_ff[14:10];
	assign phy_addr_p3        = addr_ff[19:15];

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_an_restart_set: assert property ( // [RQ1]
		(!in_load && ctrl_ff[0][phy_cfg_pkg::CTRL_AN_EN] && cfg0_rise)
		|=> ctrl_ff[0][phy_cfg_pkg::CTRL_AN_RESTART] ##1 autoneg_restart[0])
		else $error("autoneg restart not raised after cfg0 rise");

	chk_speed_follow: assert property ( // [RQ2]
		(in_track && !rst_active && !an_s && nxt_mode == phy_cfg_pkg::MODE_TRACK)
		|=> ctrl_ff[0][phy_cfg_pkg::CTRL_SPEED] == $past(cfg0_s))
		else $error("speed bit does not follow cfg0");

	chk_link_test: assert property ( // [RQ4]
		(in_track && !an_s && nxt_mode == phy_cfg_pkg::MODE_TRACK)
		|=> cfg_ff[0][phy_cfg_pkg::CFG_LINK_TEST_DIS] == $past(cfg1_s))
		else $error("link test bit does not follow cfg1");

	chk_fx_scrambler: assert property ( // [RQ6]
		cfg_ff[1][phy_cfg_pkg::CFG_FX] |=> scrambler_bypassed[1])
		else $error("fiber port scrambler not bypassed");

	chk_all_duplex: assert property ( // [RQ9]
		(in_track && fde_s && nxt_mode == phy_cfg_pkg::MODE_TRACK)
		|=> ctrl_ff[2][phy_cfg_pkg::CTRL_DUPLEX] ##1 full_duplex[2])
		else $error("all-port full duplex not applied");

	chk_fiber_duplex: assert property ( // [RQ10]
		(in_track && !fde_s && !port_fx_s[3] && (an_s || !cfg2_s)
		&& nxt_mode == phy_cfg_pkg::MODE_TRACK)
		|=> !ctrl_ff[3][phy_cfg_pkg::CTRL_DUPLEX])
		else $error("fiber duplex pin acted on twisted-pair port");

	chk_phy_addr: assert property ( // [RQ14]
		resetn |=> phy_addr_p2 == {$past(strap_s), 2'b10})
		else $error("port 2 management address wrong");

	chk_reset_hold: assert property ( // [RQ16]
		rst_trigger |=> rst_active [*8])
		else $error("internal reset not held after soft reset");

	chk_power_down: assert property ( // [RQ17]
		pd_s |=> power_down[0] && power_down[3])
		else $error("power-down pin not applied");

	chk_track_ro: assert property ( // [RQ19]
		(reg_wr && in_track && $past(in_track) && nxt_mode == phy_cfg_pkg::MODE_TRACK
		&& $stable(pin_s) && $stable(port_fx_s))
		|=> $stable(cfg_ff[0]) && $stable(cfg_ff[1]))
		else $error("write accepted while management disabled");

	logic an_bit_any;

	assign an_bit_any = |nxt_an;

	cov_restart: cover property (cfg0_rise && an_bit_any);
	cov_soft_reset: cover property (in_soft ##1 rst_trigger);
	cov_fiber_port: cover property (in_track && fx_mode[0] && full_duplex[0]);
endmodule : phy_hw_config

// ===== phy_cfg_pkg.sv
// constants of the quad transceiver hardware configuration block
package phy_cfg_pkg;
	// clock and reset extension timing
	localparam int CLK_PERIOD_PS    = 5000;
	localparam int RESET_EXT_NS     = 205000;
	// nominal time, rounded down to whole cycles
	localparam int RESET_EXT_CYC    = (RESET_EXT_NS * 1000) / CLK_PERIOD_PS;
	localparam int RESET_CNT_W      = 17;
	localparam int SYNC_STAGES      = 2;

	// geometry of the management register space
	localparam int NUM_PORTS        = 4;
	localparam int ADDR_W           = 7;
	localparam int DATA_W           = 16;
	localparam int PORT_SEL_LSB     = 5;
	localparam int PHY_ADDR_W       = 5;

	// register numbers within one port
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADV  = 5'h04;
	localparam logic [4:0] REG_CFG  = 5'h13;

	// control register fields
	localparam int CTRL_RESET       = 15;
	localparam int CTRL_SPEED       = 13;
	localparam int CTRL_AN_EN       = 12;
	localparam int CTRL_POWER_DOWN_PIN       = 11;
	localparam int CTRL_AN_RESTART  = 9;
	localparam int CTRL_DUPLEX      = 8;

	// configuration register fields
	localparam int CFG_LINK_TEST_DIS = 8;
	localparam int CFG_SCR_BYPASS    = 3;
	localparam int CFG_FX            = 2;

	// advertisement field positions
	localparam int ADV_10_HD        = 5;
	localparam int ADV_10_FD        = 6;
	localparam int ADV_100_HD       = 7;
	localparam int ADV_100_FD       = 8;

	// software writable bits and reset values
	localparam logic [15:0] CTRL_WR_MASK = 16'hBB00;
	localparam logic [15:0] CFG_WR_MASK  = 16'h010C;
	localparam logic [15:0] REG_RST_VAL  = 16'h0000;

	// who drives the register bits
	typedef enum logic [1:0] {
		MODE_LOAD  = 2'b00,
		MODE_TRACK = 2'b01,
		MODE_SOFT  = 2'b11
	} ctrl_mode_t;
endpackage : phy_cfg_pkg

// ===== cfg_sync.sv
// two flip-flop synchroniser for a group of pin levels
module cfg_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : cfg_sync

// ===== reset_stretch.sv
// holds the internal reset for a fixed count after its sources go away
module reset_stretch #(
	parameter int CYC = 1
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic trigger,
	output logic      active
);
	localparam logic [phy_cfg_pkg::RESET_CNT_W-1:0] LOAD = CYC[phy_cfg_pkg::RESET_CNT_W-1:0];

	logic [phy_cfg_pkg::RESET_CNT_W-1:0] cnt_ff;
	logic [phy_cfg_pkg::RESET_CNT_W-1:0] nxt_cnt;
	logic                                active_ff;

	assign nxt_cnt = trigger ? LOAD : ((cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff    <= LOAD;
			active_ff <= 1'b1;
		end else begin
			cnt_ff    <= nxt_cnt;
			active_ff <= (nxt_cnt != '0);
		end
	end

	assign active = active_ff;
endmodule : reset_stretch

// ===== strap_board.sv
// board strap wiring and per-port interface select pins for the configuration block
module strap_board (
	input  wire logic        clk,
	input  wire logic [11:0] setting,
	input  wire logic [3:0]  fx_sel,
	output logic             cfg0_pin,
	output logic             cfg1_pin,
	output logic             cfg2_pin,
	output logic             all_port_full_duplex_pin,
	output logic             fiber_full_duplex_pin,
	output logic             scrambler_bypass_pin,
	output logic             autoneg_enable_pin,
	output logic             phy_addr_strap_bit4,
	output logic             phy_addr_strap_bit3,
	output logic             phy_addr_strap_bit2,
	output logic             power_down_pin,
	output logic             management_disable_pin,
	output logic [3:0]       port_fx_select_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// setting bits: {mdis,pwr,an,byp, fdfx,fd,cfg2,cfg1, cfg0,a4,a3,a2}
	// fiber chosen through cfg2 always comes with 100 Mbps on cfg0
	assign cfg0_pin                 = setting[3] | (setting[5] & ~setting[9]);
	assign cfg1_pin                 = setting[4];
	assign cfg2_pin                 = setting[5];
	assign all_port_full_duplex_pin = setting[6];
	assign fiber_full_duplex_pin    = setting[7];
	assign scrambler_bypass_pin     = setting[8];
	assign autoneg_enable_pin       = setting[9];
	assign power_down_pin           = setting[10];
	assign management_disable_pin   = setting[11];
	assign phy_addr_strap_bit4      = setting[2];
	assign phy_addr_strap_bit3      = setting[1];
	assign phy_addr_strap_bit2      = setting[0];
	assign port_fx_select_pin       = fx_sel;
endmodule : strap_board

// ===== quad_phy_hw_config_straps_tb.sv
// self-checking bench for the hardware configuration block
module quad_phy_hw_config_straps_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, reg_wr, reg_rd, device_reset, mgmt_read_only;
	logic cfg0_pin, cfg1_pin, cfg2_pin, all_port_full_duplex_pin, fiber_full_duplex_pin;
	logic scrambler_bypass_pin, autoneg_enable_pin, power_down_pin, management_disable_pin;
	logic phy_addr_strap_bit4, phy_addr_strap_bit3, phy_addr_strap_bit2;
	logic [11:0] setting;
	logic [3:0]  fx_sel, port_fx_select_pin, adv_ability, restart_val;
	logic [3:0]  speed_100, autoneg_en, autoneg_restart, full_duplex;
	logic [3:0]  link_test_dis, fx_mode, scrambler_bypassed, power_down;
	logic [6:0]  reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [4:0]  phy_addr_p0, phy_addr_p1, phy_addr_p2, phy_addr_p3;
	int          errors, num_checks, restarts, n;

	strap_board u_strap_board (.clk, .setting, .fx_sel, .cfg0_pin, .cfg1_pin, .cfg2_pin,
		.all_port_full_duplex_pin, .fiber_full_duplex_pin, .scrambler_bypass_pin,
		.autoneg_enable_pin, .phy_addr_strap_bit4, .phy_addr_strap_bit3, .phy_addr_strap_bit2,
		.power_down_pin, .management_disable_pin, .port_fx_select_pin);

	phy_hw_config #(.RESET_EXT_CYC(20)) u_phy_hw_config (.clk, .resetn, .cfg0_pin, .cfg1_pin,
		.cfg2_pin, .all_port_full_duplex_pin, .fiber_full_duplex_pin, .scrambler_bypass_pin,
		.autoneg_enable_pin, .phy_addr_strap_bit4, .phy_addr_strap_bit3, .phy_addr_strap_bit2,
		.power_down_pin, .management_disable_pin, .port_fx_select_pin, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .device_reset, .mgmt_read_only,
		.speed_100, .autoneg_en, .autoneg_restart, .full_duplex, .link_test_dis, .fx_mode,
		.scrambler_bypassed, .power_down, .adv_ability, .phy_addr_p0, .phy_addr_p1,
		.phy_addr_p2, .phy_addr_p3);

	// continuous 5 ns reference clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// restart pulses are one cycle long, so count them as they pass
	always @(posedge clk) begin
		if (resetn === 1'b1 && autoneg_restart !== 4'h0) begin
			restarts++;
			restart_val = autoneg_restart;
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected value at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check

	task automatic results;
		$display("checks %0d, errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results

	// bounded wait for the internal reset to end; m counts the cycles spent
	task automatic wait_ready(output int m);
		m = 0;
		while (device_reset !== 1'b0) begin
			@(posedge clk);
			#1;
			m++;
			if (m > 40) begin
				errors++;
				$display("unexpected hang at %0t: device reset stuck", $time);
				results();
			end
		end
	endtask : wait_ready

	task automatic do_reset;
		resetn <= 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		repeat (15) @(posedge clk);
		#1;
		check(device_reset, 1'b1);
		wait_ready(n);
		check(n >= 5 && n <= 8, 1'b1);
		repeat (2) @(posedge clk);
	endtask : do_reset

	task automatic set_pins(input logic [11:0] v, input logic [3:0] f);
		@(posedge clk);
		setting <= v;
		fx_sel <= f;
		repeat (8) @(posedge clk);
		#1;
	endtask : set_pins

	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd

	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 7'h00;
		reg_wdata = 16'h0000;
		setting = 12'h91D;
		fx_sel = 4'h0;
		errors = 0;
		num_checks = 0;
		restarts = 0;
		do_reset();
		// pins in control: 100M, link test off, twisted pair, bypass high
		set_pins(12'h91D, 4'h0);
		check({speed_100, link_test_dis, fx_mode, scrambler_bypassed}, 16'hFF0F);
		check(mgmt_read_only, 1'b1);
		check({phy_addr_p1, phy_addr_p0}, {5'h15, 5'h14});
		check({phy_addr_p3, phy_addr_p2}, {5'h17, 5'h16});
		rd(7'h13, d);
		check(d, 16'h0108);
		wr(7'h00, 16'h0000);
		rd(7'h00, d);
		check(d, 16'h2000);
		rd(7'h05, d);
		check(d, 16'h0000);
		// fiber through cfg2: scrambler forced off, fiber duplex applies
		set_pins(12'h8AD, 4'h0);
		check({fx_mode, scrambler_bypassed, full_duplex, speed_100}, 16'hFFFF);
		rd(7'h73, d);
		check(d, 16'h000C);
		// fiber on port 1 only: fiber duplex ignored on twisted pair ports
		set_pins(12'h885, 4'h2);
		set_pins(12'h88D, 4'h2);
		check({fx_mode, scrambler_bypassed, full_duplex, speed_100}, 16'h222F);
		check(16'(restarts), 16'h0000);
		set_pins(12'h845, 4'h0);
		check({full_duplex, speed_100, fx_mode}, 12'hF00);
		set_pins(12'hC05, 4'h0);
		check(power_down, 4'hF);
		// autoneg on: advertisement and restart on cfg0 rising
		set_pins(12'hA55, 4'h0);
		check({autoneg_en, adv_ability}, 8'hFC);
		set_pins(12'hA5D, 4'h0);
		check(16'(restarts), 16'h0001);
		check(restart_val, 4'hF);
		set_pins(12'hA05, 4'h0);
		check(adv_ability, 4'h1);
		// software ownership after a reset with management enabled
		set_pins(12'h00D, 4'h0);
		do_reset();
		set_pins(12'h005, 4'h0);
		check({speed_100, mgmt_read_only}, 5'h1E);
		wr(7'h00, 16'h0800);
		wr(7'h33, 16'h0100);
		repeat (4) @(posedge clk);
		#1;
		check({power_down, speed_100, link_test_dis}, 12'h1E2);
		rd(7'h00, d);
		check(d, 16'h0800);
		wr(7'h40, 16'h8000);
		repeat (2) @(posedge clk);
		#1;
		check(device_reset, 1'b1);
		wait_ready(n);
		repeat (4) @(posedge clk);
		#1;
		check({power_down, speed_100, link_test_dis}, 12'h000);
		results();
	end
endmodule : quad_phy_hw_config_straps_tb
